// ===== bench/led_bank_model.sv
// LED bank model: the lamps that the active-low button outputs sink.
// Assumes each output drives strong both ways, so no pull level applies.
`timescale 1ns/1ps
module led_bank_model #(
  parameter int NCH = 10
) (
  input  wire logic [NCH-1:0] buttonOutput_n,
  output logic      [NCH-1:0] ledLit
);
  // Lamp conducts only while its pin pulls low
  assign ledLit = ~buttonOutput_n;
endmodule

// ===== bench/testbench.sv
// Testbench: strap table, then hand-written touch, hold, timeout cases.
// Assumes the LED bank model on the outputs and short timing parameters.
`timescale 1ns/1ps
module testbench;
  import touch_out_pkg::*;
  typedef struct packed {
    logic [1:0]  tn;
    logic [1:0]  ts;
    logic [7:0]  hr;
    logic [31:0] cfg;
  } row_s;
  logic                      sys_clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      sampleValid = 1'b0;
  logic [NUM_CH*COUNT_W-1:0] rawCount = '0;
  logic [1:0]                timeoutNoiseStrap = 2'h0;
  logic [1:0]                toggleSuppressStrap = 2'h0;
  logic [7:0]                holdTimeResistor = 8'h00;
  logic [ADDR_W-1:0]         avs_address = 4'h0;
  logic                      avs_read = 1'b0;
  logic                      avs_write = 1'b0;
  logic [DATA_W-1:0]         avs_writedata = 32'h0;
  logic [DATA_W-1:0]         avs_readdata;
  logic                      avs_waitrequest;
  logic [NUM_CH-1:0]         buttonOutput_n;
  logic [NUM_CH-1:0]         ledLit;
  logic                      highNoiseImmunity;
  logic                      debugEnable;
  logic [31:0]               rd;
  int                        nFail = 0;
  int                        numChecks = 0;
  row_s                      rows [4];

  always #5 sys_clk = ~sys_clk;

  // Short timeout and hold step keep the run brief
  touch_button_output_logic #(.TIMEOUT_CYC(200), .STEP_CYC(10)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .sampleValid(sampleValid),
    .rawCount(rawCount), .timeoutNoiseStrap(timeoutNoiseStrap),
    .toggleSuppressStrap(toggleSuppressStrap), .holdTimeResistor(holdTimeResistor),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .buttonOutput_n(buttonOutput_n),
    .highNoiseImmunity(highNoiseImmunity), .debugEnable(debugEnable));

  led_bank_model #(.NCH(NUM_CH)) led_u (
    .buttonOutput_n(buttonOutput_n), .ledLit(ledLit));

  // ------------------------------------------------------------
  // Checks and drivers
  // ------------------------------------------------------------
  task automatic chk10(input string nm, input logic [9:0] e, input logic [9:0] g);
    numChecks++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  // Waitrequest judged at each rising edge; the edge that sees it low ends the transfer
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    if (n >= 100) nFail++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk32(nm, e, rd);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Touched channels sit 0x80 counts above the seeded baseline
  task automatic touch(input logic [9:0] m);
    @(posedge sys_clk);
    for (int i = 0; i < NUM_CH; i++) begin
      rawCount[i*COUNT_W +: COUNT_W] <= m[i] ? 16'h0180 : 16'h0100;
    end
    sampleValid <= 1'b1;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
    waitCyc(3);
  endtask

  task automatic doReset(input logic [1:0] tn, input logic [1:0] ts, input logic [7:0] hr);
    @(posedge sys_clk);
    timeoutNoiseStrap <= tn;
    toggleSuppressStrap <= ts;
    holdTimeResistor <= hr;
    reset <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    waitCyc(12);
    touch(10'h000);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    rows[0] = '{2'h0, 2'h0, 8'h03, 32'h0000_0030};
    rows[1] = '{2'h1, 2'h1, 8'h63, 32'h0000_0635};
    rows[2] = '{2'h2, 2'h2, 8'h65, 32'h0000_081A};
    rows[3] = '{2'h3, 2'h3, 8'h7F, 32'h0000_09BF};
    for (int r = 0; r < 4; r++) begin
      doReset(rows[r].tn, rows[r].ts, rows[r].hr);
      rdChk(OFS_CONFIG, rows[r].cfg, "config");
      chk10("pins", {8'h00, rows[r].cfg[11], rows[r].cfg[1]},
            {8'h00, debugEnable, highNoiseImmunity});
      @(posedge sys_clk);
      timeoutNoiseStrap <= ~rows[r].tn;
      toggleSuppressStrap <= ~rows[r].ts;
      holdTimeResistor <= 8'h40;
      waitCyc(12);
      rdChk(OFS_CONFIG, rows[r].cfg, "latched");
      rdChk(OFS_THRESH, {16'h0000, THRESH_RST}, "thresh");
    end
    doReset(2'h0, 2'h0, 8'h00);
    touch(10'h080);
    chk10("press", 10'h080, ledLit);
    rdChk(OFS_CONTROL, 32'h0000_0080, "touched");
    touch(10'h000);
    chk10("release", 10'h000, ledLit);
    bus(1'b1, OFS_THRESH, 32'h0000_0200);
    touch(10'h080);
    chk10("weak", 10'h000, ledLit);
    bus(1'b1, OFS_STATUS, 32'h000F_FFFF);
    rdChk(OFS_STATUS, 32'h0, "ro status");
    rdChk(4'h2, 32'h0, "unmapped");
    doReset(2'h0, 2'h0, 8'h03);
    touch(10'h004);
    touch(10'h000);
    chk10("held", 10'h004, ledLit);
    waitCyc(40);
    chk10("hold end", 10'h000, ledLit);
    touch(10'h003);
    touch(10'h002);
    chk10("first held", 10'h003, ledLit);
    touch(10'h000);
    chk10("shared", 10'h002, ledLit);
    doReset(2'h1, 2'h0, 8'h03);
    touch(10'h001);
    chk10("stuck on", 10'h001, ledLit);
    waitCyc(250);
    chk10("stuck off", 10'h000, ledLit);
    rdChk(OFS_STATUS, 32'h0000_0400, "timed out");
    touch(10'h000);
    chk10("no hold", 10'h000, ledLit);
    doReset(2'h0, 2'h1, 8'h03);
    touch(10'h010);
    chk10("toggle on", 10'h010, ledLit);
    touch(10'h000);
    chk10("ignore up", 10'h010, ledLit);
    touch(10'h010);
    chk10("toggle off", 10'h000, ledLit);
    touch(10'h000);
    chk10("no hold", 10'h000, ledLit);
    doReset(2'h0, 2'h2, 8'h00);
    touch(10'h002);
    touch(10'h00A);
    chk10("flank", 10'h002, ledLit);
    touch(10'h000);
    touch(10'h060);
    chk10("tie", 10'h020, ledLit);
    tally_and_finish();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    nFail++;
    tally_and_finish();
  end
endmodule

// ===== logic/touch_button_output_logic.sv
// Top: ten touch channels to ten active-low button outputs, with straps.
// Assumes strap and count inputs are static or from the sensing front end;
// straps are asynchronous pins and are synchronised before use.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Ten inputs, ten active-low outputs, one-to-one.
// - Stuck touch released after timeout period.
// - Timeout strap gives timeout and noise level.
// - Toggle mode inverts output on each press.
// - Toggle strap gives toggle and suppression.
// - Suppression allows only first touched button.
// - Hold output low after release, 20 ms steps.
// - Hold strap code gives steps and debug.
// - No hold after timeout release.
// - Toggle mode disables hold.
// - One shared hold timer, restarted by releases.
// - Sensitivity set at power-up, then tracked.
// - Touch means count shift above threshold.
module touch_button_output_logic
  import touch_out_pkg::*;
#(
  parameter int     NCH         = NUM_CH,
  parameter longint TIMEOUT_CYC = TIMEOUT_CYCLES,
  parameter int     STEP_CYC    = STEP_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              sampleValid,
  input  wire logic [NCH*COUNT_W-1:0] rawCount,
  input  wire logic [1:0]        timeoutNoiseStrap,
  input  wire logic [1:0]        toggleSuppressStrap,
  input  wire logic [7:0]        holdTimeResistor,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [NCH-1:0]    buttonOutput_n,
  output logic                   highNoiseImmunity,
  output logic                   debugEnable
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    phase_e                 phase;
    logic [2:0]             initCnt;
    logic [1:0]             tnSync1, tnSync2;
    logic [1:0]             tsSync1, tsSync2;
    logic [7:0]             hrSync1, hrSync2;
    logic                   timeoutEn;
    logic                   highNoise;
    logic                   toggleEn;
    logic                   suppressEn;
    logic [6:0]             holdSteps;
    logic                   debugEn;
    logic [NCH-1:0]         touchPrev;
    logic [NCH-1:0]         on;
    logic [NCH-1:0]         timedOut;
    logic [NCH-1:0]         holding;
    logic [NCH-1:0][31:0]   stuckCnt;
    logic [31:0]            holdCnt;
    logic [6:0]             holdStepCnt;
    logic [COUNT_W-1:0]     threshold;
    logic                   ack;
    logic [DATA_W-1:0]      rdata;
  } top_s;

  top_s s_q;
  top_s s_d;
  logic [NCH-1:0] touched;

  touch_classifier #(.NCH(NCH), .CW(COUNT_W)) u_cls (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .sampleValid (sampleValid),
    .rawCount    (rawCount),
    .threshold   (s_q.threshold),
    .touched     (touched)
  );

  // Lowest index wins a same-cycle tie under suppression
  function automatic logic [NCH-1:0] firstOne(input logic [NCH-1:0] v);
    firstOne = v & (~v + 1'b1);
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [NCH-1:0] rise, fall, want, grant;
    logic           anyFall;
    rise = '0; fall = '0; want = '0; grant = '0; anyFall = 1'b0;
    s_d = s_q;
    s_d.tnSync1 = timeoutNoiseStrap;
    s_d.tnSync2 = s_q.tnSync1;
    s_d.tsSync1 = toggleSuppressStrap;
    s_d.tsSync2 = s_q.tsSync1;
    s_d.hrSync1 = holdTimeResistor;
    s_d.hrSync2 = s_q.hrSync1;
    s_d.ack     = 1'b0;

    case (s_q.phase)
      ST_INIT: begin
        s_d.initCnt = s_q.initCnt + 3'h1;
        if (s_q.initCnt == 3'(INIT_CYCLES)) begin
          // Straps captured once; settings stay fixed until reset
          s_d.timeoutEn  = (s_q.tnSync2 == STRAP_RES1) || (s_q.tnSync2 == STRAP_VDD);
          s_d.highNoise  = (s_q.tnSync2 == STRAP_RES2) || (s_q.tnSync2 == STRAP_VDD);
          s_d.toggleEn   = (s_q.tsSync2 == STRAP_RES1) || (s_q.tsSync2 == STRAP_VDD);
          s_d.suppressEn = (s_q.tsSync2 == STRAP_RES2) || (s_q.tsSync2 == STRAP_VDD);
          // Code = (ohms-300)/30; codes from 100 up are the debug band
          if (s_q.hrSync2[6:0] >= DEBUG_BASE_STEP || s_q.hrSync2[7]) begin
            s_d.debugEn   = 1'b1;
            s_d.holdSteps = s_q.hrSync2[7] ? HOLD_STEPS_MAX
                          : 7'(s_q.hrSync2[6:0] - DEBUG_BASE_STEP);
          end else begin
            s_d.debugEn   = 1'b0;
            s_d.holdSteps = s_q.hrSync2[6:0];
          end
          s_d.phase = ST_RUN;
        end
      end
      ST_RUN: begin
        rise    = touched & ~s_q.touchPrev;
        fall    = ~touched & s_q.touchPrev;
        anyFall = |fall;
        s_d.touchPrev = touched;
        for (int i = 0; i < NCH; i++) begin
          // Stuck counter only runs during continuous contact
          if (touched[i] && !s_q.timedOut[i]) s_d.stuckCnt[i] = s_q.stuckCnt[i] + 32'h1;
          else if (!touched[i]) s_d.stuckCnt[i] = '0;
          if (!touched[i]) s_d.timedOut[i] = 1'b0;
        end
        if (s_q.toggleEn) begin
          want = s_q.on ^ rise;
        end else begin
          want = touched & ~s_q.timedOut;
        end
        if (s_q.suppressEn) begin
          // An existing owner keeps the output; newcomers wait
          if (|(s_q.on & want)) grant = firstOne(s_q.on & want);
          else grant = firstOne(want);
        end else begin
          grant = want;
        end
        for (int i = 0; i < NCH; i++) begin
          if (s_q.timeoutEn && grant[i] && touched[i] && !s_q.timedOut[i]
              && s_q.stuckCnt[i] >= 32'(TIMEOUT_CYC)) begin
            grant[i]          = 1'b0;
            s_d.timedOut[i]   = 1'b1;
            s_d.stuckCnt[i]   = '0;
          end
        end
        s_d.on = grant;
        // Shared hold timer; a new release cuts any earlier hold short
        if (anyFall) begin
          s_d.holding     = (s_q.toggleEn || s_q.holdSteps == '0) ? '0
                          : (fall & s_q.on & ~s_q.timedOut);
          s_d.holdCnt     = '0;
          s_d.holdStepCnt = '0;
        end else if (|s_q.holding) begin
          if (s_q.holdCnt == 32'(STEP_CYC - 1)) begin
            s_d.holdCnt     = '0;
            s_d.holdStepCnt = s_q.holdStepCnt + 7'h1;
            if (s_q.holdStepCnt + 7'h1 >= s_q.holdSteps) s_d.holding = '0;
          end else begin
            s_d.holdCnt = s_q.holdCnt + 32'h1;
          end
        end
        s_d.holding = s_d.holding & ~touched;
      end
      default: s_d.phase = ST_INIT;
    endcase

    // Avalon slave: one wait cycle, then answer
    s_d.rdata = '0;
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      if (avs_write && avs_address == OFS_THRESH) s_d.threshold = avs_writedata[COUNT_W-1:0];
      if (avs_read) begin
        if (avs_address == OFS_STATUS) s_d.rdata = DATA_W'({s_q.timedOut, s_q.on});
        else if (avs_address == OFS_CONFIG)
          s_d.rdata = DATA_W'({s_q.debugEn, s_q.holdSteps, s_q.suppressEn, s_q.toggleEn,
                               s_q.highNoise, s_q.timeoutEn});
        else if (avs_address == OFS_THRESH) s_d.rdata = DATA_W'(s_q.threshold);
        else if (avs_address == OFS_CONTROL) s_d.rdata = DATA_W'(touched);
        else s_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q           <= '0;
      s_q.phase     <= ST_INIT;
      s_q.threshold <= THRESH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign buttonOutput_n    = ~(s_q.on | s_q.holding);
  assign avs_waitrequest   = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata      = s_q.rdata;
  assign highNoiseImmunity = s_q.highNoise;
  assign debugEnable       = s_q.debugEn;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence sRelease0;
    s_q.phase == ST_RUN ##1 $fell(touched[0]);
  endsequence

  a_one_hot_on: assert property (@(posedge sys_clk) disable iff (reset)
    s_q.suppressEn |-> $onehot0(s_q.on)) else $error("several buttons on");
  a_plain_follow: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.phase == ST_RUN && !s_q.toggleEn && !s_q.suppressEn && !s_q.timeoutEn)
      |=> s_q.on == $past(touched)) else $error("output not following");
  a_toggle_flip: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.phase == ST_RUN && s_q.toggleEn && !s_q.suppressEn && $rose(touched[4]))
      |=> s_q.on[4] != $past(s_q.on[4])) else $error("toggle missed");
  a_toggle_nohold: assert property (@(posedge sys_clk) disable iff (reset)
    s_q.toggleEn |-> s_q.holding == '0) else $error("hold in toggle");
  a_timeout_nohold: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.timedOut & s_q.holding) == '0) else $error("hold after timeout");
  a_hold_start: assert property (@(posedge sys_clk) disable iff (reset)
    sRelease0 ##0 ($past(s_q.on[0]) && !s_q.toggleEn && s_q.holdSteps != '0
                    && !$past(s_q.timedOut[0])) |=> s_q.holding[0]) else $error("no hold");
  a_shared_timer: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.phase == ST_RUN && |(~touched & s_q.touchPrev)) |=> s_q.holdCnt == '0)
    else $error("timer not restarted");
  a_straps_fixed: assert property (@(posedge sys_clk) disable iff (reset)
    ($past(s_q.phase) == ST_RUN) |-> $stable(s_q.holdSteps) && $stable(s_q.toggleEn))
    else $error("strap setting moved");
  a_timeout_off: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.timedOut & s_q.on) == '0) else $error("timed out still on");
  a_strap_decode: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.phase == ST_INIT && s_q.initCnt == 3'(INIT_CYCLES))
      |=> s_q.timeoutEn == ($past(s_q.tnSync2) == STRAP_RES1
                            || $past(s_q.tnSync2) == STRAP_VDD))
    else $error("timeout decode");

endmodule

// ===== logic/touch_classifier.sv
// Touch classifier: baseline tracking and threshold compare per channel.
// Assumes count samples arrive on sys_clk with a one-cycle valid strobe.
`timescale 1ns/1ps
module touch_classifier
  import touch_out_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter int CW  = COUNT_W
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              sampleValid,
  input  wire logic [NCH*CW-1:0] rawCount,
  input  wire logic [CW-1:0]     threshold,
  output logic      [NCH-1:0]    touched
);

  typedef struct packed {
    logic [NCH-1:0][CW-1:0] base;
    logic [NCH-1:0]         seeded;
    logic [NCH-1:0]         touched;
  } cls_s;

  cls_s s_q;
  cls_s s_d;

  function automatic logic [CW-1:0] shiftOf(input logic [CW-1:0] c, input logic [CW-1:0] b);
    shiftOf = (c > b) ? CW'(c - b) : '0;
  endfunction

  always_comb begin
    logic [CW-1:0] c;
    c = '0;
    s_d = s_q;
    if (sampleValid) begin
      for (int i = 0; i < NCH; i++) begin
        c = rawCount[i*CW +: CW];
        if (!s_q.seeded[i]) begin
          // Baseline is learnt at power-up without external tuning
          s_d.base[i]   = c;
          s_d.seeded[i] = 1'b1;
        end else begin
          s_d.touched[i] = shiftOf(c, s_q.base[i]) > threshold;
          // Slow drift tracking only while untouched, so a held finger is not absorbed
          if (!s_d.touched[i]) begin
            if (c > s_q.base[i]) s_d.base[i] = CW'(s_q.base[i] + 1'b1);
            else if (c < s_q.base[i]) s_d.base[i] = CW'(s_q.base[i] - 1'b1);
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) s_q <= '0;
    else s_q <= s_d;
  end

  assign touched = s_q.touched;

  a_touch_needs_shift: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(touched[0]) |-> $past(sampleValid)) else $error("touch without sample");

endmodule

// ===== logic/touch_out_pkg.sv
// Package: constants and types for the ten-channel touch button output logic.
// Assumes a 100 MHz sys_clk; strap levels arrive already digitised as codes.
package touch_out_pkg;

  // ------------------------------------------------------------
  // Sizes and bus
  // ------------------------------------------------------------
  localparam int          NUM_CH        = 10;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam int          COUNT_W       = 16;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONFIG  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_THRESH  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'hC;

  // ------------------------------------------------------------
  // Reset values and strap codes
  // ------------------------------------------------------------
  localparam logic [COUNT_W-1:0] THRESH_RST = 16'h0040;
  localparam logic [1:0]  STRAP_GND     = 2'h0;
  localparam logic [1:0]  STRAP_RES1    = 2'h1;
  localparam logic [1:0]  STRAP_RES2    = 2'h2;
  localparam logic [1:0]  STRAP_VDD     = 2'h3;
  localparam logic [6:0]  HOLD_STEPS_MAX = 7'h64;
  localparam logic [6:0]  DEBUG_BASE_STEP = 7'h64;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          TIMEOUT_S     = 20;
  localparam int          HOLD_STEP_MS  = 20;
  localparam int          MS_CYCLES     = CLK_HZ / 1000;
  localparam int          STEP_CYCLES   = HOLD_STEP_MS * MS_CYCLES;
  localparam longint      TIMEOUT_CYCLES = longint'(TIMEOUT_S) * CLK_HZ;
  localparam int          INIT_CYCLES   = 4;

  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } phase_e;

endpackage
